// file: hw/gms_sequencer.sv
// Operating mode sequencer of a two-player driving game
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "gms_defines.svh"

module gms_sequencer
  import gms_pkg::*;
#(
  parameter int TICK_CYC = `GMS_TICK_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_opt_toggles,
  input  wire logic        i_coin,
  input  wire logic        i_start1,
  input  wire logic        i_start2,
  input  wire logic        i_track_sel,
  input  wire logic        i_chk_white,
  input  wire logic        i_chk_black,
  input  wire logic        i_self_test,
  input  wire logic        i_selftest_end,
  input  wire logic        i_pix_on,
  input  wire logic        i_gray_scan,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output gms_state_t       o_mode,
  output logic [3:0]       o_track,
  output logic [6:0]       o_timer,
  output logic [7:0]       o_score_white,
  output logic [7:0]       o_score_black,
  output gms_rate_t        o_rate_white,
  output gms_rate_t        o_rate_black,
  output gms_disp_t        o_disp,
  output logic [7:0]       o_opt_show,
  output gms_vid_t         o_video
);

  // ***************
  // Helpers
  // ***************
  function automatic logic [7:0] game_secs(input logic t7, input logic t8);
    logic [7:0] s;
    s = `GMS_TIME_60;
    unique case ({t7, t8})
      2'b11: s = `GMS_TIME_150;
      2'b10: s = `GMS_TIME_120;
      2'b01: s = `GMS_TIME_90;
      2'b00: s = `GMS_TIME_60;
    endcase
    return s;
  endfunction

  // Price codes: 11 one per player, 10 one for two, 01 two per player, 00 free
  function automatic logic [2:0] coins_need(input logic [1:0] pr, input logic two);
    logic [2:0] n;
    n = 3'h0;
    unique case (pr)
      2'b11: n = two ? 3'h2 : 3'h1;
      2'b10: n = 3'h1;
      2'b01: n = two ? 3'h4 : 3'h2;
      2'b00: n = 3'h0;
    endcase
    return n;
  endfunction

  function automatic gms_rate_t rating(input logic [7:0] sc);
    gms_rate_t r;
    r = RATE_GRANNY;
    if (sc >= `GMS_PRO_MIN) begin
      r = RATE_PRO;
    end else if (sc >= `GMS_ROOKIE_MIN) begin
      r = RATE_ROOKIE;
    end
    return r;
  endfunction

  // ***************
  // State
  // ***************
  localparam int TW = $clog2(TICK_CYC);

  gms_state_t    state_r, state_nxt;
  logic [3:0]    track_r, track_nxt;
  logic [6:0]    timer_r, timer_nxt;
  logic [7:0]    sw_r, sw_nxt;
  logic [7:0]    sb_r, sb_nxt;
  logic [10:0]   ph_r, ph_nxt;
  logic          ext_used_r, ext_used_nxt;
  logic [2:0]    coins_r;
  logic [2:0]    coins_nxt;
  logic [TW-1:0] tick_cnt_r;
  logic          coin_prev_r;
  logic          trk_prev_r;
  logic          s1_prev_r;
  logic          s2_prev_r;
  logic          show_r;
  logic [8:0]    opt_ovr_r;
  logic [31:0]   rdata_r;
  gms_vid_t      vid_r;

  // ***************
  // Decode
  // ***************
  wire logic [7:0] opt_raw   = opt_ovr_r[`GMS_OPT_OVR_BIT] ? opt_ovr_r[7:0] : i_opt_toggles;
  wire gms_opt_t   opt       = gms_opt_t'(opt_raw);
  wire logic [1:0] price     = {opt.t4, opt.t3};
  wire logic [7:0] gsec      = game_secs(opt.t7, opt.t8);
  wire logic       tick      = (tick_cnt_r == TW'(TICK_CYC - 1));
  wire logic       coin_clr  = coin_prev_r & ~i_coin;
  wire logic       trk_p     = i_track_sel & ~trk_prev_r;
  wire logic       s1_p      = i_start1 & ~s1_prev_r;
  wire logic       s2_p      = i_start2 & ~s2_prev_r;
  wire logic [2:0] need1     = coins_need(price, 1'b0);
  wire logic [2:0] need2     = coins_need(price, 1'b1);
  wire logic       leave_ok  = (coins_r >= need1);
  wire logic       go2       = s2_p & (coins_r >= need2);
  wire logic       go1       = s1_p & (coins_r >= need1);
  wire logic       go        = (state_r == ST_START) & (go1 | go2);
  wire logic [2:0] cost      = go2 ? need2 : need1;
  wire logic       step_hit  = tick & (ph_r == {3'h0, gsec} - 11'h001);
  wire logic       attr_hit  = tick & (ph_r == 11'(`GMS_ATTR_TICKS - 1));
  wire logic       frz_hit   = tick & (ph_r == 11'(`GMS_FREEZE_TICKS - 1));
  wire logic       pro_any   = (rating(sw_r) == RATE_PRO) | (rating(sb_r) == RATE_PRO);
  wire logic       extend    = opt.ext_play & pro_any & ~ext_used_r;
  wire logic [3:0] track_inc = (track_r == `GMS_LAST_TRACK) ? 4'h0 : track_r + 4'h1;
  wire logic [2:0] coin_add  = (coin_clr && coins_r != 3'h7) ? 3'h1 : 3'h0;
  wire logic [2:0] coin_sub  = go ? cost : 3'h0;

  assign coins_nxt = coins_r + coin_add - coin_sub;

  // ***************
  // Mode sequencing
  // ***************
  always_comb begin
    state_nxt    = state_r;
    track_nxt    = track_r;
    timer_nxt    = timer_r;
    sw_nxt       = sw_r;
    sb_nxt       = sb_r;
    ext_used_nxt = ext_used_r;
    ph_nxt       = tick ? ph_r + 11'h001 : ph_r;
    unique case (state_r)
      ST_ATTRACT: begin
        if (opt.attract_easy) begin
          track_nxt = 4'h0;
        end else if (attr_hit) begin
          track_nxt = track_inc;
          ph_nxt    = 11'h000;
        end
        if (leave_ok) begin
          state_nxt = ST_START;
          track_nxt = 4'h0;
          ph_nxt    = 11'h000;
        end
      end
      ST_START: begin
        if (trk_p) begin
          track_nxt = track_inc;
        end
        if (go) begin
          state_nxt    = ST_PLAY;
          timer_nxt    = `GMS_TIMER_FULL;
          ph_nxt       = 11'h000;
          ext_used_nxt = 1'b0;
          sw_nxt       = 8'h00;
          sb_nxt       = 8'h00;
        end
      end
      ST_PLAY: begin
        if (i_chk_white) begin
          sw_nxt = sw_r + `GMS_SCORE_STEP;
        end
        if (i_chk_black) begin
          sb_nxt = sb_r + `GMS_SCORE_STEP;
        end
        if (timer_r == 7'h00) begin
          ph_nxt = 11'h000;
          if (extend) begin
            timer_nxt    = `GMS_TIMER_EXT;
            ext_used_nxt = 1'b1;
          end else begin
            state_nxt = ST_FREEZE;
          end
        end else if (step_hit) begin
          timer_nxt = timer_r - 7'h01;
          ph_nxt    = 11'h000;
        end
      end
      ST_FREEZE: begin
        if (frz_hit) begin
          state_nxt = ST_ATTRACT;
          ph_nxt    = 11'h000;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r    <= ST_ATTRACT;
      track_r    <= 4'h0;
      timer_r    <= 7'h00;
      sw_r       <= 8'h00;
      sb_r       <= 8'h00;
      ph_r       <= 11'h000;
      ext_used_r <= 1'b0;
      coins_r    <= 3'h0;
    end else begin
      state_r    <= state_nxt;
      track_r    <= track_nxt;
      timer_r    <= timer_nxt;
      sw_r       <= sw_nxt;
      sb_r       <= sb_nxt;
      ph_r       <= ph_nxt;
      ext_used_r <= ext_used_nxt;
      coins_r    <= coins_nxt;
    end
  end

  // Free-running tick keeps all mode timing on one 10 ms base
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
    end
  end

  // Track and start edge memories start high so a button held through reset is no press; the coin memory starts low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      coin_prev_r <= 1'b0;
      trk_prev_r  <= 1'b1;
      s1_prev_r   <= 1'b1;
      s2_prev_r   <= 1'b1;
    end else begin
      coin_prev_r <= i_coin;
      trk_prev_r  <= i_track_sel;
      s1_prev_r   <= i_start1;
      s2_prev_r   <= i_start2;
    end
  end

  // ***************
  // Self-test and video
  // ***************
  wire logic show_nxt = (i_self_test & i_selftest_end) | (show_r & i_self_test);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      show_r <= 1'b0;
      vid_r  <= VID_BLACK;
    end else begin
      show_r <= show_nxt;
      vid_r  <= !i_pix_on ? VID_BLACK : (i_gray_scan ? VID_GREY : VID_WHITE);
    end
  end

  // ***************
  // Register port
  // ***************
  wire logic        wr_opt  = i_wr & (i_addr == `GMS_REG_OPT);
  wire logic [31:0] st_word = {12'h000, ext_used_r, coins_r, 1'b0, timer_r, track_r, 2'b00, state_r};
  wire logic [31:0] sc_word = {16'h0000, sb_r, sw_r};
  wire logic [31:0] rd_sel  = (i_addr == `GMS_REG_STATUS) ? st_word :
                              (i_addr == `GMS_REG_SCORE)  ? sc_word :
                              (i_addr == `GMS_REG_OPT)    ? {23'h000000, opt_ovr_r} : 32'h00000000;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      opt_ovr_r <= `GMS_OPT_RST;
      rdata_r   <= 32'h00000000;
    end else begin
      if (wr_opt) begin
        opt_ovr_r <= i_wdata[8:0];
      end
      rdata_r <= i_rd ? rd_sel : 32'h00000000;
    end
  end

  // ***************
  // Outputs
  // ***************
  wire logic in_att = (state_r == ST_ATTRACT);
  wire logic in_st  = (state_r == ST_START);
  wire logic in_pl  = (state_r == ST_PLAY);
  wire logic in_fz  = (state_r == ST_FREEZE);

  assign o_rdata       = rdata_r;
  assign o_mode        = state_r;
  assign o_track       = track_r;
  assign o_timer       = timer_r;
  assign o_score_white = sw_r;
  assign o_score_black = sb_r;
  assign o_rate_white  = rating(sw_r);
  assign o_rate_black  = rating(sb_r);
  assign o_opt_show    = show_r ? opt_raw : 8'h00;
  assign o_video       = vid_r;

  // Toggle 6 feeds nothing; only shown in self-test
  assign o_disp.auto_cycle    = in_att & ~opt.attract_easy;
  assign o_disp.cars_at_line  = in_st;
  assign o_disp.ctrl_en       = in_pl;
  assign o_disp.motor         = in_pl ? 2'b11 : 2'b00;
  assign o_disp.prompt_start  = in_st;
  assign o_disp.prompt_track  = in_st | (in_pl & (track_r != 4'h0));
  assign o_disp.cars_frozen   = in_fz;
  assign o_disp.game_over_vis = in_fz & ph_r[`GMS_BLINK_BIT];
  assign o_disp.rate_show     = in_fz;
  assign o_disp.oil_en        = opt.oil;
  assign o_disp.price_msg     = in_att ? price : 2'b00;
  assign o_disp.show_opts     = show_r;

  // ***************
  // Checks
  // ***************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_play_ends;
    (state_r == ST_PLAY) ##1 (state_r == ST_FREEZE);
  endsequence

  sequence s_freeze_ends;
    (state_r == ST_FREEZE) ##1 (state_r == ST_ATTRACT);
  endsequence

  chk_reset_attract: assert property (disable iff (1'b0) !i_rst_n |=> state_r == ST_ATTRACT)
    else $error("mode not attract after reset");

  chk_leave_attract: assert property ((state_r == ST_ATTRACT) ##1 (state_r == ST_START) |->
    $past(coins_r) >= $past(need1))
    else $error("attract left without credit");

  chk_start_entry: assert property ($rose(state_r == ST_START) |-> track_r == 4'h0 && o_disp.cars_at_line)
    else $error("start mode entry wrong");

  chk_track_wrap: assert property (in_st && trk_p && !go && track_r == `GMS_LAST_TRACK |=> track_r == 4'h0)
    else $error("track did not wrap");

  chk_timer_load: assert property (go |=> in_pl && timer_r == `GMS_TIMER_FULL)
    else $error("play start timer wrong");

  chk_play_outputs: assert property (in_pl |-> o_disp.ctrl_en && o_disp.motor == 2'b11 && !o_disp.prompt_start)
    else $error("play outputs wrong");

  chk_score_step: assert property (in_pl && i_chk_white && !go |=> sw_r == $past(sw_r) + 8'h02)
    else $error("white score step wrong");

  chk_freeze_entry: assert property (s_play_ends |-> $past(timer_r) == 7'h00 && !$past(extend))
    else $error("freeze entered early");

  chk_freeze_len: assert property (s_freeze_ends |-> $past(ph_r) == 11'(`GMS_FREEZE_TICKS - 1))
    else $error("freeze length wrong");

  chk_attract_quiet: assert property (in_att |-> o_disp.motor == 2'b00 && !o_disp.ctrl_en)
    else $error("sound in attract");

  chk_game_time: assert property (opt.t7 && !opt.t8 |-> gsec == `GMS_TIME_120)
    else $error("game time code wrong");

  chk_grey_level: assert property (o_video == VID_GREY |-> $past(i_gray_scan) && $past(i_pix_on))
    else $error("grey outside car scan");

endmodule

// file: include/gms_defines.svh
// Offsets, field positions, reset values and timing counts of the mode sequencer
`ifndef GMS_DEFINES_SVH
`define GMS_DEFINES_SVH
// ***************
// Register map
// ***************
`define GMS_REG_STATUS   8'h00
`define GMS_REG_SCORE    8'h04
`define GMS_REG_OPT      8'h08
`define GMS_OPT_RST      9'h000
`define GMS_OPT_OVR_BIT  8
// ***************
// Timing
// ***************
`define GMS_CLK_MHZ      125
`define GMS_TICK_MS      10
`define GMS_TICK_CYC     (`GMS_TICK_MS * `GMS_CLK_MHZ * 1000)
`define GMS_FREEZE_S     10
`define GMS_FREEZE_TICKS (`GMS_FREEZE_S * 1000 / `GMS_TICK_MS)
`define GMS_ATTR_MS      3000
`define GMS_ATTR_TICKS   (`GMS_ATTR_MS / `GMS_TICK_MS)
`define GMS_BLINK_BIT    5
// ***************
// Game constants
// ***************
`define GMS_TIMER_FULL   7'h64
`define GMS_TIMER_EXT    7'h1E
`define GMS_LAST_TRACK   4'hB
`define GMS_SCORE_STEP   8'h02
`define GMS_TIME_150     8'h96
`define GMS_TIME_120     8'h78
`define GMS_TIME_90      8'h5A
`define GMS_TIME_60      8'h3C
`define GMS_ROOKIE_MIN   8'h14
`define GMS_PRO_MIN      8'h28
`endif

// file: include/gms_pkg.sv
// Types shared by the mode sequencer
package gms_pkg;
  typedef enum logic [1:0] {
    ST_ATTRACT,
    ST_START,
    ST_PLAY,
    ST_FREEZE
  } gms_state_t;

  typedef enum logic [1:0] {
    RATE_GRANNY,
    RATE_ROOKIE,
    RATE_PRO
  } gms_rate_t;

  typedef enum logic [1:0] {
    VID_BLACK,
    VID_GREY,
    VID_WHITE
  } gms_vid_t;

  // Toggle 8 in the top bit, toggle 1 in the bottom bit
  typedef struct packed {
    logic t8;
    logic t7;
    logic unused6;
    logic ext_play;
    logic t4;
    logic t3;
    logic attract_easy;
    logic oil;
  } gms_opt_t;

  typedef struct packed {
    logic       auto_cycle;
    logic       cars_at_line;
    logic       ctrl_en;
    logic [1:0] motor;
    logic       prompt_start;
    logic       prompt_track;
    logic       cars_frozen;
    logic       game_over_vis;
    logic       rate_show;
    logic       oil_en;
    logic [1:0] price_msg;
    logic       show_opts;
  } gms_disp_t;
endpackage

// file: sim/gms_partner.sv
// Coin mechanism and pushbutton model facing the sequencer
`timescale 1ns/10ps

module gms_partner (
  input  wire logic i_clk,
  output logic      o_coin,
  output logic      o_start1,
  output logic      o_start2,
  output logic      o_track_sel,
  output logic      o_chk_white,
  output logic      o_chk_black
);
  // ****************
  // Idle levels
  // ****************
  initial begin
    o_coin      = 1'b0;
    o_start1    = 1'b0;
    o_start2    = 1'b0;
    o_track_sel = 1'b0;
    o_chk_white = 1'b0;
    o_chk_black = 1'b0;
  end

  // ****************
  // Actions
  // ****************
  // Coin dwells a few cycles, credit only once it clears
  task automatic coin();
    @(posedge i_clk);
    o_coin <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_coin <= 1'b0;
  endtask

  // 0 start1, 1 track, 2 white checkpoint, 3 black checkpoint, else start2
  task automatic press(input int which);
    @(posedge i_clk);
    case (which)
      0: o_start1 <= 1'b1;
      1: o_track_sel <= 1'b1;
      2: o_chk_white <= 1'b1;
      3: o_chk_black <= 1'b1;
      default: o_start2 <= 1'b1;
    endcase
    @(posedge i_clk);
    {o_start1, o_start2, o_track_sel, o_chk_white, o_chk_black} <= 5'h00;
    // Low gap so the next press is a fresh edge
    @(posedge i_clk);
  endtask
endmodule

// file: sim/test_game_mode_sequencer.sv
// Self-checking testbench of the mode sequencer
`timescale 1ns/10ps
`include "gms_defines.svh"

module test_game_mode_sequencer
  import gms_pkg::*;
;
  logic        i_clk, i_rst_n, i_self_test, i_selftest_end, i_pix_on, i_gray_scan, i_wr, i_rd;
  logic        i_coin, i_start1, i_start2, i_track_sel, i_chk_white, i_chk_black;
  logic [7:0]  i_opt_toggles, i_addr, o_opt_show, o_score_white, o_score_black;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  o_track;
  logic [6:0]  o_timer;
  gms_state_t  o_mode;
  gms_rate_t   o_rate_white, o_rate_black;
  gms_disp_t   o_disp;
  gms_vid_t    o_video;
  int          errors, samples_checked, n;

  gms_sequencer #(.TICK_CYC(4)) gms_sequencer_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_opt_toggles(i_opt_toggles), .i_coin(i_coin), .i_start1(i_start1), .i_start2(i_start2),
    .i_track_sel(i_track_sel), .i_chk_white(i_chk_white), .i_chk_black(i_chk_black),
    .i_self_test(i_self_test), .i_selftest_end(i_selftest_end), .i_pix_on(i_pix_on),
    .i_gray_scan(i_gray_scan), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_mode(o_mode), .o_track(o_track), .o_timer(o_timer),
    .o_score_white(o_score_white), .o_score_black(o_score_black), .o_rate_white(o_rate_white),
    .o_rate_black(o_rate_black), .o_disp(o_disp), .o_opt_show(o_opt_show), .o_video(o_video));

  gms_partner gms_partner_inst (.i_clk(i_clk), .o_coin(i_coin), .o_start1(i_start1),
    .o_start2(i_start2), .o_track_sel(i_track_sel), .o_chk_white(i_chk_white),
    .o_chk_black(i_chk_black));

  // ****************
  // Clock and helpers
  // ****************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(what, exp, o_rdata);
  endtask

  // Bounded wait, returns cycles spent
  task automatic wait_mode(input gms_state_t m, input int lim, output int cnt);
    cnt = 0;
    while (o_mode !== m && cnt < lim) begin
      step(1);
      cnt++;
    end
    check("mode", 32'(m), 32'(o_mode));
  endtask

  // Bounded wait for the timer to leave a value, returns cycles spent
  task automatic wait_timer(input logic [6:0] v, output int cnt);
    cnt = 0;
    while (o_timer === v && cnt < 1000) begin
      step(1);
      cnt++;
    end
    check("timer", 32'(v) - 32'h1, 32'(o_timer));
  endtask

  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic sc_attract();
    gms_partner_inst.press(0);
    step(2);
    check("mode", 32'(ST_ATTRACT), 32'(o_mode));
    check("mode", 32'(ST_ATTRACT), 32'(o_mode));
    check("price", 32'h3, 32'(o_disp.price_msg));
    check("motor", 32'h0, 32'(o_disp.motor));
    check("cycle", 32'h1, 32'(o_disp.auto_cycle));
    // First attract track change lands 300 ticks after reset
    step(1200);
    check("track", 32'h1, 32'(o_track));
  endtask

  task automatic sc_coin_tracks();
    gms_partner_inst.coin();
    step(1);
    check("mode", 32'(ST_ATTRACT), 32'(o_mode));
    wait_mode(ST_START, 4, n);
    check("track", 32'h0, 32'(o_track));
    check("cars", 32'h1, 32'(o_disp.cars_at_line));
    check("cycle", 32'h0, 32'(o_disp.auto_cycle));
    for (int k = 1; k <= 12; k++) begin
      gms_partner_inst.press(1);
      check("track", 32'(k % 12), 32'(o_track));
    end
  endtask

  task automatic sc_play();
    gms_partner_inst.press(0);
    check("mode", 32'(ST_PLAY), 32'(o_mode));
    check("timer", 32'(`GMS_TIMER_FULL), 32'(o_timer));
    check("ctrl", 32'h1, 32'(o_disp.ctrl_en));
    check("motor", 32'h3, 32'(o_disp.motor));
    check("prompts", 32'h0, 32'({o_disp.prompt_start, o_disp.prompt_track}));
    check("oil", 32'h1, 32'(o_disp.oil_en));
    gms_partner_inst.press(2);
    gms_partner_inst.press(2);
    gms_partner_inst.press(3);
    check("white", 32'h4, 32'(o_score_white));
    check("black", 32'h2, 32'(o_score_black));
    reg_rd(8'h04, 32'h0000_0204, "score_reg");
    gms_partner_inst.press(1);
    check("track", 32'h0, 32'(o_track));
  endtask

  // 60 s setting, 100 steps of 60 ticks of 4 cycles
  task automatic sc_freeze();
    wait_mode(ST_FREEZE, 25000, n);
    check("short", 32'h1, 32'(n > 23000));
    check("frozen", 32'h1, 32'({o_disp.cars_frozen, o_disp.rate_show} == 2'h3));
    check("rate", 32'(RATE_GRANNY), 32'(o_rate_white));
    wait_mode(ST_ATTRACT, 4200, n);
    check("hold", 32'h1, 32'(n > 3900));
  endtask

  task automatic sc_misc();
    reg_wr(8'h08, 32'h0000_010D);
    reg_rd(8'h08, 32'h0000_010D, "opt_reg");
    reg_rd(8'h0C, 32'h0, "unmapped");
    i_self_test <= 1'b1;
    i_selftest_end <= 1'b1;
    step(1);
    i_selftest_end <= 1'b0;
    step(2);
    check("opt_show", 32'h0D, 32'(o_opt_show));
    i_pix_on <= 1'b1;
    i_gray_scan <= 1'b1;
    step(2);
    check("video", 32'(VID_GREY), 32'(o_video));
    i_gray_scan <= 1'b0;
    step(2);
    check("video", 32'(VID_WHITE), 32'(o_video));
  endtask

  // Free play after mid-run reset, step lengths, pro extension
  task automatic sc_free_ext();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_opt_toggles <= 8'h72;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    step(2);
    check("mode", 32'(ST_START), 32'(o_mode));
    check("oil", 32'h0, 32'(o_disp.oil_en));
    check("opt_show", 32'h0, 32'(o_opt_show));
    reg_rd(8'h00, 32'h0000_0001, "status");
    reg_rd(8'h08, 32'h0, "opt_rst");
    gms_partner_inst.press(4);
    check("mode", 32'(ST_PLAY), 32'(o_mode));
    for (int k = 0; k < 20; k++) begin
      gms_partner_inst.press(2);
    end
    check("rate", 32'(RATE_PRO), 32'(o_rate_white));
    check("rate_b", 32'(RATE_GRANNY), 32'(o_rate_black));
    wait_timer(7'h64, n);
    wait_timer(7'h63, n);
    check("step120", 32'h1E0, 32'(n));
    i_opt_toggles <= 8'hB2;
    wait_timer(7'h62, n);
    check("step90", 32'h168, 32'(n));
    i_opt_toggles <= 8'h32;
    n = 0;
    while (o_timer !== 7'h00 && n < 24000) begin
      step(1);
      n++;
    end
    step(1);
    check("ext", 32'h1E, 32'(o_timer));
    wait_mode(ST_FREEZE, 7400, n);
    check("ext_len", 32'h1, 32'(n > 7100));
    check("blink", 32'h0, 32'(o_disp.game_over_vis));
    step(140);
    check("blink", 32'h1, 32'(o_disp.game_over_vis));
    wait_mode(ST_ATTRACT, 4000, n);
    check("cycle", 32'h0, 32'(o_disp.auto_cycle));
    step(1);
    check("mode", 32'(ST_START), 32'(o_mode));
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    errors = 0;
    samples_checked = 0;
    i_rst_n = 1'b0;
    i_opt_toggles = 8'h0D;
    {i_self_test, i_selftest_end, i_pix_on, i_gray_scan, i_wr, i_rd} = 6'h00;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    sc_attract();
    sc_coin_tracks();
    sc_play();
    sc_freeze();
    sc_misc();
    sc_free_ext();
    close_out();
  end

  // Whole run needs about 66000 cycles
  initial begin
    #(8 * 80000);
    errors++;
    close_out();
  end
endmodule
